// ==== src/rms_pkg.sv ====
package rms_pkg;

  // ==========================================================================
  // Register map, byte addresses on the bus.
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_OUTCFG = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;

  // ==========================================================================
  // Control register fields.
  localparam int MODE_LSB   = 0;
  localparam int POLICY_LSB = 2;
  localparam int REFSEL_BIT = 4;
  localparam logic [4:0] CTRL_RST = 5'h02;

  // ==========================================================================
  // Output configuration fields.
  localparam int KIND_C0_LSB = 0;
  localparam int KIND_C1_LSB = 2;
  localparam int OE_LSB      = 4;
  localparam logic [5:0] OUTCFG_RST = 6'h30;

  // ==========================================================================
  // Timing.
  localparam int CLK_PERIOD_NS = 10;
  localparam int PSL_STEP_NS   = 100;
  localparam int PSL_STEP_CYC  = (PSL_STEP_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int MISS_EDGES    = 3;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {
    RMS_SYNTH = 2'b00,
    RMS_HBW   = 2'b01,
    RMS_LBW   = 2'b10
  } rms_mode_t;

  typedef enum logic [1:0] {
    RMS_MAN_PIN = 2'b00,
    RMS_MAN_REG = 2'b01,
    RMS_AUTO_RV = 2'b10,
    RMS_AUTO_NR = 2'b11
  } rms_policy_t;

  typedef enum logic [2:0] {
    RMS_ST_ACQ   = 3'b001,
    RMS_ST_TRACK = 3'b010,
    RMS_ST_HOLD  = 3'b100
  } rms_state_t;

  typedef enum logic [1:0] {
    RMS_SRC_REF  = 2'b00,
    RMS_SRC_XTAL = 2'b01,
    RMS_SRC_VCO  = 2'b10
  } rms_src_t;

  typedef struct packed {
    logic active_ref;
    logic holdover;
    logic ref1_fail_alarm;
    logic ref0_fail_alarm;
    logic crystal_fail_alarm;
    logic pll_locked_flag;
  } rms_alarm_t;

endpackage : rms_pkg

// ==== src/rms_edge_mon.sv ====
`timescale 1ns/1ps

module rms_edge_mon #(
  parameter int MISS = rms_pkg::MISS_EDGES
) (
  // Clock and reset.
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Edge pulses.
  input  wire logic fb_edge_i,
  input  wire logic mon_edge_i,
  // Alarm.
  output logic      fail_o
);

  if (MISS < 1 || MISS > 255) begin : g_bad_miss
    $error("rms_edge_mon: MISS out of range");
  end

  logic [7:0] miss_q;

  // ==========================================================================
  // Counts feedback edges since the last monitored edge; holds once the alarm is set.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      miss_q <= 8'h00;
    end else if (mon_edge_i) begin
      miss_q <= 8'h00;
    end else if (fb_edge_i && !fail_o) begin
      miss_q <= miss_q + 8'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fail_o <= 1'b0;
    end else if (mon_edge_i) begin
      fail_o <= 1'b0;
    end else if (fb_edge_i && miss_q == 8'(MISS - 1)) begin
      fail_o <= 1'b1;
    end
  end

  // ==========================================================================
  // Checks.
  property p_fail_clear;
    @(posedge clk_i) disable iff (rst_i)
      mon_edge_i |=> !fail_o;
  endproperty
  a_fail_clear: assert property (p_fail_clear)
    else $error("alarm stayed after monitored edge");

  property p_fail_rise;
    @(posedge clk_i) disable iff (rst_i)
      $rose(fail_o) |-> $past(fb_edge_i) && !$past(mon_edge_i);
  endproperty
  a_fail_rise: assert property (p_fail_rise)
    else $error("alarm rose without feedback edge");

endmodule : rms_edge_mon

// ==== src/rms_ref_switch.sv ====
`timescale 1ns/1ps

module rms_ref_switch #(
  parameter int PHASE_W = 8,
  parameter int PSL_CYC = rms_pkg::PSL_STEP_CYC
) (
  // Clock and reset.
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  // Wishbone slave.
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [31:0]        wb_dat_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic               wb_we_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  output logic [31:0]             wb_dat_o,
  output logic                    wb_ack_o,
  // Clock sources and loop feedback.
  input  wire logic               ref_in_zero_i,
  input  wire logic               ref_in_one_i,
  input  wire logic               xtal_i,
  input  wire logic               fb_upper_i,
  input  wire logic               fb_lower_i,
  input  wire logic               freq_lock_i,
  input  wire logic [PHASE_W-1:0] phase_lag_i,
  // Pins.
  input  wire logic               clk_sel_i,
  input  wire logic               cfg_sel_i,
  input  wire logic [1:0]         out_enable_n_i,
  // Status and control outputs.
  output rms_pkg::rms_alarm_t     alarm_o,
  output rms_pkg::rms_src_t       osc_src_o,
  output logic [1:0]              out_kind_o,
  output logic [1:0]              out_oe_o,
  output logic                    phase_stretch_o,
  output logic                    slewing_o
);

  if (PHASE_W < 1 || PSL_CYC < 3) begin : g_bad_param
    $error("rms_ref_switch: PHASE_W or PSL_CYC out of range");
  end

  // ==========================================================================
  // Registers and decode.
  logic [4:0]            ctrl_q;
  logic [5:0]            outcfg_q;
  logic                  ack_q;
  logic [31:0]           rdat_q;
  rms_pkg::rms_mode_t    mode;
  rms_pkg::rms_policy_t  policy;
  logic                  pref;
  logic                  wr_en;

  assign mode   = rms_pkg::rms_mode_t'(ctrl_q[rms_pkg::MODE_LSB +: 2]);
  assign policy = rms_pkg::rms_policy_t'(ctrl_q[rms_pkg::POLICY_LSB +: 2]);
  assign pref   = ctrl_q[rms_pkg::REFSEL_BIT];
  assign wr_en  = wb_cyc_i && wb_stb_i && wb_we_i && ack_q && wb_sel_i[0];

  function automatic logic is_auto(input rms_pkg::rms_policy_t p);
    is_auto = (p == rms_pkg::RMS_AUTO_RV) || (p == rms_pkg::RMS_AUTO_NR);
  endfunction : is_auto

  function automatic logic ref_ok(input logic r, input logic f0,
                                  input logic f1);
    ref_ok = r ? !f1 : !f0;
  endfunction : ref_ok

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= rms_pkg::CTRL_RST;
    end else if (wr_en && wb_adr_i == rms_pkg::ADDR_CTRL) begin
      ctrl_q <= wb_dat_i[4:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      outcfg_q <= rms_pkg::OUTCFG_RST;
    end else if (wr_en && wb_adr_i == rms_pkg::ADDR_OUTCFG) begin
      outcfg_q <= wb_dat_i[5:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else begin
      case (wb_adr_i)
        rms_pkg::ADDR_CTRL:   rdat_q <= {27'h000_0000, ctrl_q};
        rms_pkg::ADDR_OUTCFG: rdat_q <= {26'h000_0000, outcfg_q};
        rms_pkg::ADDR_STATUS: rdat_q <= {26'h000_0000, alarm_o};
        default:              rdat_q <= 32'h0000_0000;
      endcase
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ==========================================================================
  // Edge detection and clock monitors.
  logic [4:0] lvl_q;
  logic [4:0] edge_w;
  logic       fb_edge;
  logic       fail0;
  logic       fail1;
  logic       xfail;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_q <= 5'h00;
    end else begin
      lvl_q <= {fb_lower_i, fb_upper_i, xtal_i, ref_in_one_i, ref_in_zero_i};
    end
  end

  assign edge_w  = {fb_lower_i, fb_upper_i, xtal_i, ref_in_one_i,
                    ref_in_zero_i} & ~lvl_q;
  assign fb_edge = (mode == rms_pkg::RMS_LBW) ? edge_w[4] : edge_w[3];

  // Monitors run in every mode, relevant or not.
  rms_edge_mon u_mon_xtal (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .fb_edge_i  (edge_w[3]),
    .mon_edge_i (edge_w[2]),
    .fail_o     (xfail)
  );

  rms_edge_mon u_mon_ref0 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .fb_edge_i  (fb_edge),
    .mon_edge_i (edge_w[0]),
    .fail_o     (fail0)
  );

  rms_edge_mon u_mon_ref1 (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .fb_edge_i  (fb_edge),
    .mon_edge_i (edge_w[1]),
    .fail_o     (fail1)
  );

  // ==========================================================================
  // Reference selection.
  rms_pkg::rms_state_t state_q;
  rms_pkg::rms_state_t state_d;
  logic                active_q;
  logic                active_d;
  logic                msel;
  logic                locked_q;

  assign msel = (policy == rms_pkg::RMS_MAN_PIN) ? clk_sel_i : pref;

  always_comb begin
    state_d  = state_q;
    active_d = active_q;
    if (!is_auto(policy)) begin
      active_d = msel;
      state_d  = ref_ok(msel, fail0, fail1) ? rms_pkg::RMS_ST_TRACK
                                            : rms_pkg::RMS_ST_HOLD;
    end else begin
      case (state_q)
        rms_pkg::RMS_ST_ACQ: begin
          active_d = pref;
          if (fail0 && fail1) begin
            state_d = rms_pkg::RMS_ST_HOLD;
          end else if (freq_lock_i && ref_ok(pref, fail0, fail1)) begin
            state_d = rms_pkg::RMS_ST_TRACK;
          end
        end
        rms_pkg::RMS_ST_TRACK: begin
          if (!ref_ok(active_q, fail0, fail1)) begin
            if (ref_ok(!active_q, fail0, fail1)) begin
              active_d = !active_q;
            end else begin
              state_d = rms_pkg::RMS_ST_HOLD;
            end
          end else if (active_q != pref && ref_ok(pref, fail0, fail1) &&
                       policy == rms_pkg::RMS_AUTO_RV) begin
            active_d = pref;
          end
        end
        rms_pkg::RMS_ST_HOLD: begin
          if (!fail0 && !fail1) begin
            active_d = pref;
            state_d  = rms_pkg::RMS_ST_TRACK;
          end else if (!fail0 || !fail1) begin
            active_d = fail0;
            state_d  = rms_pkg::RMS_ST_TRACK;
          end
        end
        default: begin
          state_d = rms_pkg::RMS_ST_ACQ;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= rms_pkg::RMS_ST_ACQ;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      locked_q <= 1'b0;
    end else begin
      locked_q <= freq_lock_i && (state_d != rms_pkg::RMS_ST_HOLD);
    end
  end

  assign alarm_o = '{active_ref:         active_q,
                     holdover:           state_q == rms_pkg::RMS_ST_HOLD,
                     ref1_fail_alarm:    fail1,
                     ref0_fail_alarm:    fail0,
                     crystal_fail_alarm: xfail,
                     pll_locked_flag:    locked_q};

  // ==========================================================================
  // Phase slope limiting and holdover source.
  logic [PHASE_W-1:0] slew_q;
  logic [15:0]        step_q;
  logic               stretch_q;
  logic               hold;
  rms_pkg::rms_src_t  src_q;

  assign hold = (state_q == rms_pkg::RMS_ST_HOLD);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      slew_q <= '0;
    end else if (active_d != active_q ||
                 (hold && state_d == rms_pkg::RMS_ST_TRACK)) begin
      slew_q <= phase_lag_i;
    end else if (stretch_q) begin
      slew_q <= slew_q - PHASE_W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      step_q <= 16'h0000;
    end else if (hold || slew_q == '0 || step_q == 16'(PSL_CYC - 1)) begin
      step_q <= 16'h0000;
    end else begin
      step_q <= step_q + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stretch_q <= 1'b0;
    end else begin
      stretch_q <= !hold && slew_q != '0 && !stretch_q &&
                   step_q == 16'(PSL_CYC - 1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      src_q <= rms_pkg::RMS_SRC_XTAL;
    end else if (mode == rms_pkg::RMS_SYNTH) begin
      src_q <= rms_pkg::RMS_SRC_XTAL;
    end else if (state_d == rms_pkg::RMS_ST_HOLD) begin
      src_q <= (mode == rms_pkg::RMS_LBW) ? rms_pkg::RMS_SRC_XTAL
                                          : rms_pkg::RMS_SRC_VCO;
    end else begin
      src_q <= rms_pkg::RMS_SRC_REF;
    end
  end

  assign phase_stretch_o = stretch_q;
  assign slewing_o       = (slew_q != '0) && !hold;
  assign osc_src_o       = src_q;

  // ==========================================================================
  // Output type and enable.
  logic [1:0] kind_q;
  logic [1:0] oe_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      kind_q <= 2'b00;
    end else begin
      kind_q <= cfg_sel_i ? outcfg_q[rms_pkg::KIND_C1_LSB +: 2]
                          : outcfg_q[rms_pkg::KIND_C0_LSB +: 2];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      oe_q <= 2'b00;
    end else begin
      oe_q <= outcfg_q[rms_pkg::OE_LSB +: 2] & ~out_enable_n_i;
    end
  end

  assign out_kind_o = kind_q;
  assign out_oe_o   = oe_q;

  // ==========================================================================
  // Checks.
  property p_lock_drop;
    @(posedge clk_i) disable iff (rst_i)
      !freq_lock_i |=> !alarm_o.pll_locked_flag;
  endproperty
  a_lock_drop: assert property (p_lock_drop)
    else $error("lock flag stayed without lock");

  property p_manual_hold;
    @(posedge clk_i) disable iff (rst_i)
      !is_auto(policy) && !ref_ok(msel, fail0, fail1) |=> alarm_o.holdover;
  endproperty
  a_manual_hold: assert property (p_manual_hold)
    else $error("manual mode missed holdover");

  property p_auto_no_hold;
    @(posedge clk_i) disable iff (rst_i)
      is_auto(policy) && (!fail0 || !fail1) |=> !alarm_o.holdover;
  endproperty
  a_auto_no_hold: assert property (p_auto_no_hold)
    else $error("auto holdover with a valid input");

  property p_revert;
    @(posedge clk_i) disable iff (rst_i)
      policy == rms_pkg::RMS_AUTO_RV && state_q == rms_pkg::RMS_ST_TRACK &&
      active_q != pref && ref_ok(pref, fail0, fail1) |=>
      active_q == $past(pref);
  endproperty
  a_revert: assert property (p_revert)
    else $error("revertive mode did not return");

  property p_no_revert;
    @(posedge clk_i) disable iff (rst_i)
      policy == rms_pkg::RMS_AUTO_NR && state_q == rms_pkg::RMS_ST_TRACK &&
      ref_ok(active_q, fail0, fail1) |=> $stable(active_q);
  endproperty
  a_no_revert: assert property (p_no_revert)
    else $error("non-revertive mode switched");

  property p_stretch_rate;
    @(posedge clk_i) disable iff (rst_i)
      phase_stretch_o |=> !phase_stretch_o [*2];
  endproperty
  a_stretch_rate: assert property (p_stretch_rate)
    else $error("phase stretched too fast");

  property p_hold_freeze;
    @(posedge clk_i) disable iff (rst_i)
      alarm_o.holdover |=> !phase_stretch_o;
  endproperty
  a_hold_freeze: assert property (p_hold_freeze)
    else $error("phase adjusted in holdover");

  property p_oe_and;
    @(posedge clk_i) disable iff (rst_i)
      out_enable_n_i[0] || !outcfg_q[rms_pkg::OE_LSB] |=> !out_oe_o[0];
  endproperty
  a_oe_and: assert property (p_oe_and)
    else $error("output 0 enabled without both enables");

endmodule : rms_ref_switch

// ==== tb/rms_src_model.sv ====
`timescale 1ns/1ps

// ==========================================================================
// Clock sources: bit0 ref zero, bit1 ref one, bit2 crystal, bit3 upper
// feedback, bit4 lower feedback. A stopped source stands still low.
module rms_src_model (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Run control per source.
  input  wire logic [4:0] run_i,
  // Source levels.
  output logic [4:0]      line_o
);
  logic [1:0] cnt_q;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line_o <= 5'h00;
    end else begin
      line_o <= run_i & {5{cnt_q[1]}};
    end
  end
endmodule : rms_src_model

// ==== tb/rms_ref_switch_tb.sv ====
`timescale 1ns/1ps

module rms_ref_switch_tb;
  logic                clk_i = 1'b0;
  logic                rst_i;
  logic [7:0]          wb_adr_i;
  logic [31:0]         wb_dat_i;
  logic [31:0]         wb_dat_o;
  logic [3:0]          wb_sel_i;
  logic                wb_we_i;
  logic                wb_cyc_i;
  logic                wb_stb_i;
  logic                wb_ack_o;
  logic [4:0]          run;
  logic [4:0]          line;
  logic                freq_lock;
  logic                clk_sel;
  logic                cfg_sel;
  logic [1:0]          oe_n;
  rms_pkg::rms_alarm_t alarm;
  rms_pkg::rms_src_t   osc_src;
  logic [1:0]          kind;
  logic [1:0]          oe;
  logic                stretch;
  logic                slewing;
  int                  num_errors = 0;
  int                  n_checks = 0;
  int                  n_stretch = 0;
  int                  snap;

  always #5 clk_i = ~clk_i;

  always @(posedge clk_i) begin
    if (stretch === 1'b1) begin
      n_stretch <= n_stretch + 1;
    end
  end

  rms_src_model i_rms_src_model (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (run),
    .line_o (line)
  );

  rms_ref_switch #(.PSL_CYC(4)) i_rms_ref_switch (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .wb_adr_i        (wb_adr_i),
    .wb_dat_i        (wb_dat_i),
    .wb_sel_i        (wb_sel_i),
    .wb_we_i         (wb_we_i),
    .wb_cyc_i        (wb_cyc_i),
    .wb_stb_i        (wb_stb_i),
    .wb_dat_o        (wb_dat_o),
    .wb_ack_o        (wb_ack_o),
    .ref_in_zero_i   (line[0]),
    .ref_in_one_i    (line[1]),
    .xtal_i          (line[2]),
    .fb_upper_i      (line[3]),
    .fb_lower_i      (line[4]),
    .freq_lock_i     (freq_lock),
    .phase_lag_i     (8'h03),
    .clk_sel_i       (clk_sel),
    .cfg_sel_i       (cfg_sel),
    .out_enable_n_i  (oe_n),
    .alarm_o         (alarm),
    .osc_src_o       (osc_src),
    .out_kind_o      (kind),
    .out_oe_o        (oe),
    .phase_stretch_o (stretch),
    .slewing_o       (slewing)
  );

  // ==========================================================================
  // Reporting.
  task automatic close_out;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      num_errors++;
    end
  endtask : check

  task automatic done(input string name);
    $display("test %s finished", name);
  endtask : done

  // ==========================================================================
  // Stimulus helpers.
  task automatic settle(input int n);
    repeat (n) @(negedge clk_i);
  endtask : settle

  task automatic drv(input logic [4:0] r, input logic s, input logic [1:0] o,
                     input logic c, input logic l);
    @(posedge clk_i);
    run       <= r;
    clk_sel   <= s;
    oe_n      <= o;
    cfg_sel   <= c;
    freq_lock <= l;
  endtask : drv

  task automatic wb_cycle(input logic [7:0] a, input logic w,
                          input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk_i);
    wb_adr_i <= a;
    wb_we_i  <= w;
    wb_dat_i <= d;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && k < 50) begin
      @(posedge clk_i);
      k++;
    end
    if (wb_ack_o !== 1'b1) begin
      $display("ERROR at %0t bus timeout %h %h", $time, a, d);
      num_errors++;
      close_out();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
  endtask : wb_cycle

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(a, 1'b1, d, q);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(a, 1'b0, 32'h0000_0000, q);
    check(q, exp);
  endtask : rdc

  task automatic wait_bit(input int idx, input logic v);
    int k;
    k = 0;
    @(negedge clk_i);
    while (alarm[idx] !== v && k < 300) begin
      @(negedge clk_i);
      k++;
    end
    if (alarm[idx] !== v) begin
      $display("ERROR at %0t timeout %h %h", $time, alarm[idx], v);
      num_errors++;
      close_out();
    end
    check(32'(alarm[idx]), 32'(v));
  endtask : wait_bit

  // ==========================================================================
  // Main sequence.
  initial begin
    rst_i = 1'b1;
    wb_adr_i = 8'h00;
    wb_dat_i = 32'h0000_0000;
    wb_sel_i = 4'hF;
    wb_we_i = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    run = 5'h1F;
    freq_lock = 1'b0;
    clk_sel = 1'b0;
    cfg_sel = 1'b0;
    oe_n = 2'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    rdc(rms_pkg::ADDR_CTRL, 32'h0000_0002);
    rdc(rms_pkg::ADDR_OUTCFG, 32'h0000_0030);
    rdc(rms_pkg::ADDR_STATUS, 32'h0000_0000);
    wr(8'h0C, 32'hFFFF_FFFF);
    rdc(8'h0C, 32'h0000_0000);
    wr(rms_pkg::ADDR_STATUS, 32'h0000_003F);
    rdc(rms_pkg::ADDR_STATUS, 32'h0000_0000);
    settle(2);
    check(32'(oe), 32'h0000_0003);
    done("reset");
    drv(5'h1F, 1'b0, 2'h1, 1'b0, 1'b0);
    settle(3);
    check(32'(oe), 32'h0000_0002);
    wr(rms_pkg::ADDR_OUTCFG, 32'h0000_0019);
    drv(5'h1F, 1'b0, 2'h0, 1'b0, 1'b0);
    settle(3);
    check(32'(oe), 32'h0000_0001);
    check(32'(kind), 32'h0000_0001);
    drv(5'h1F, 1'b0, 2'h0, 1'b1, 1'b0);
    settle(3);
    check(32'(kind), 32'h0000_0002);
    wr(rms_pkg::ADDR_OUTCFG, 32'h0000_0030);
    done("outputs");
    drv(5'h1B, 1'b0, 2'h0, 1'b0, 1'b0);
    wait_bit(1, 1'b1);
    rdc(rms_pkg::ADDR_STATUS, 32'h0000_0002);
    drv(5'h1F, 1'b0, 2'h0, 1'b0, 1'b0);
    settle(8);
    check(32'(alarm[1]), 32'h0000_0000);
    wr(rms_pkg::ADDR_CTRL, 32'h0000_0000);
    drv(5'h1E, 1'b0, 2'h0, 1'b0, 1'b0);
    wait_bit(2, 1'b1);
    drv(5'h1F, 1'b0, 2'h0, 1'b0, 1'b0);
    wait_bit(2, 1'b0);
    drv(5'h1D, 1'b0, 2'h0, 1'b0, 1'b0);
    wait_bit(3, 1'b1);
    drv(5'h1F, 1'b0, 2'h0, 1'b0, 1'b0);
    wait_bit(3, 1'b0);
    wr(rms_pkg::ADDR_CTRL, 32'h0000_0001);
    drv(5'h16, 1'b0, 2'h0, 1'b0, 1'b0);
    settle(60);
    check(32'(alarm[2]), 32'h0000_0000);
    wr(rms_pkg::ADDR_CTRL, 32'h0000_0002);
    wait_bit(2, 1'b1);
    drv(5'h1F, 1'b0, 2'h0, 1'b0, 1'b0);
    wait_bit(2, 1'b0);
    done("alarms");
    wr(rms_pkg::ADDR_CTRL, 32'h0000_0015);
    wait_bit(5, 1'b1);
    wr(rms_pkg::ADDR_CTRL, 32'h0000_0005);
    wait_bit(5, 1'b0);
    wr(rms_pkg::ADDR_CTRL, 32'h0000_0001);
    drv(5'h1F, 1'b1, 2'h0, 1'b0, 1'b0);
    wait_bit(5, 1'b1);
    drv(5'h1F, 1'b0, 2'h0, 1'b0, 1'b0);
    wait_bit(5, 1'b0);
    drv(5'h1E, 1'b0, 2'h0, 1'b0, 1'b0);
    wait_bit(4, 1'b1);
    check(32'(alarm[5]), 32'h0000_0000);
    check(32'(osc_src), 32'(rms_pkg::RMS_SRC_VCO));
    drv(5'h1F, 1'b0, 2'h0, 1'b0, 1'b0);
    wait_bit(4, 1'b0);
    done("manual");
    wr(rms_pkg::ADDR_CTRL, 32'h0000_000A);
    drv(5'h1F, 1'b1, 2'h0, 1'b0, 1'b1);
    settle(20);
    check(32'(alarm[5]), 32'h0000_0000);
    check(32'(alarm[0]), 32'h0000_0001);
    snap = n_stretch;
    drv(5'h1E, 1'b1, 2'h0, 1'b0, 1'b1);
    wait_bit(5, 1'b1);
    check(32'(slewing), 32'h0000_0001);
    check(32'(alarm[4]), 32'h0000_0000);
    settle(30);
    check(32'(n_stretch - snap), 32'h0000_0003);
    check(32'(slewing), 32'h0000_0000);
    drv(5'h1F, 1'b1, 2'h0, 1'b0, 1'b1);
    wait_bit(5, 1'b0);
    wr(rms_pkg::ADDR_CTRL, 32'h0000_000E);
    drv(5'h1E, 1'b1, 2'h0, 1'b0, 1'b1);
    wait_bit(5, 1'b1);
    drv(5'h1F, 1'b1, 2'h0, 1'b0, 1'b1);
    wait_bit(2, 1'b0);
    settle(20);
    check(32'(alarm[5]), 32'h0000_0001);
    drv(5'h1C, 1'b1, 2'h0, 1'b0, 1'b1);
    wait_bit(4, 1'b1);
    check(32'(osc_src), 32'(rms_pkg::RMS_SRC_XTAL));
    check(32'(alarm[0]), 32'h0000_0000);
    snap = n_stretch;
    settle(30);
    check(32'(n_stretch - snap), 32'h0000_0000);
    drv(5'h1D, 1'b1, 2'h0, 1'b0, 1'b1);
    wait_bit(4, 1'b0);
    check(32'(alarm[5]), 32'h0000_0000);
    drv(5'h1D, 1'b1, 2'h0, 1'b0, 1'b0);
    wait_bit(0, 1'b0);
    done("automatic");
    close_out();
  end
endmodule : rms_ref_switch_tb
